/* hdl/arc_cfg_if.sv */
// Settings passed from the register bank to the sample path.
// Assumes both ends run on clk_sys.
`default_nettype none
interface arc_cfg_if;
	import arc_pkg::*;
	arc_policy_t policy;
	logic mute;
	logic word_truncate_en_en;
	logic [3:0] aux_width;
	arc_wsize_t word_size;
	logic audio_err;
	modport ctrl(output policy, mute, word_truncate_en_en, aux_width, word_size,
		audio_err);
	modport filt(input policy, mute, word_truncate_en_en, aux_width, word_size,
		audio_err);
endinterface
`default_nettype wire

/* hdl/arc_ctrl_regs.sv */
// Control register bank of the audio receiver, reached over the
// control port with byte address, write strobe and read strobe.
// Assumes error sources, events and channel status come from the
// receiver core on clk_sys; lock_loss_pin is asynchronous.
// Operation
// - Unlock: oscillator clock if fallback bit 0, local clock if 1.
// - Mute bit forces every serial output data bit to zero.
// - Interrupt pin style: 00 high, 01 low, 10 open-drain low.
// - Error policy: 00 hold last good, 01 zero, 10 pass.
// - Recovered clock rate bit picks 256 or 128 times sample rate.
// - Status channel bit picks channel A or B for status register.
// - Truncation uses the selected channel's aux width for both.
// - Copy inhibit bit blocks D to E status buffer updates.
// - De-emphasis: 000 off, 001 32k, 010 44.1k, 011 48k.
// - Auto code 100 follows channel A status; off for non-audio.
// - Three four-bit output route fields, all reset to zero.
// - Run bit 0 stops the core; control port still works.
// - Clock tristate bit floats the recovered clock pin.
// - Receive input select resets 000; passthrough select 001.
// - Master bit makes device drive bit and frame clocks.
// - Word size 00 24-bit, 01 20-bit, 10 16-bit.
// - Word size 11 passes raw received data, left justified.
// - Right justify only in master, non-raw; delay bit left only.
// - Bit clock and frame clock polarity bits for the receiver.
// - Error mask bit enables register, flag, interrupt, sample.
// - The two CRC errors never change the audio sample.
// - Interrupt mask bit enables status bit and interrupt output.
// - Truncated word length is 24 minus aux width.
// - Error bits stay until read; read clears absent sources.
`default_nettype none
module arc_ctrl_regs
	import arc_pkg::*;
(
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic cp_wr_en,
	input wire logic cp_rd_en,
	input wire logic [6:0] cp_addr,
	input wire logic [7:0] cp_wdata,
	output var logic [7:0] cp_rdata_q,
	input wire logic lock_loss_pin,
	input wire logic [6:0] err_src,
	input wire logic [6:0] int_evt,
	input wire logic [3:0] cha_aux,
	input wire logic [3:0] chb_aux,
	input wire logic [3:0] cha_cs_flags,
	input wire logic [3:0] chb_cs_flags,
	input wire logic cha_preemph,
	input wire logic [1:0] cha_rate,
	input wire logic non_audio,
	input wire logic sample_valid,
	input wire logic [23:0] sample_in,
	output logic [23:0] sample_out_q,
	output logic sample_out_valid_q,
	output logic core_reset_q,
	output logic copy_update_en_q,
	output arc_coef_t deemph_coef_q,
	output logic [3:0] output0_route_sel,
	output logic [3:0] output1_route_sel,
	output logic [3:0] output2_route_sel,
	output logic [2:0] rx_input_sel,
	output logic [2:0] pass_input_sel,
	output logic port_master_sel,
	output logic bitclk_rate_sel,
	output arc_wsize_t output_word_size,
	output logic right_justify_q,
	output logic msb_delay_q,
	output logic bitclk_polarity,
	output logic frame_clk_polarity,
	output logic receive_error_flag_q,
	output logic int_pin_o_q,
	output logic int_pin_oe_n_q,
	output arc_cksrc_t recovered_master_clock_src_q,
	output logic recovered_master_clock_div128_q,
	output logic recovered_master_clock_oe_n_q
);
	logic [7:0] regs_q [8];
	logic [6:0] err_stat_q;
	logic [6:0] int_stat_q;
	logic lock_s1_q;
	logic lock_s2_q;
	logic lock_s3_q;
	logic lock_lost_q;
	logic receive_error_flag_live_q;
	arc_cfg_if cfg();

	// Plain read/write registers; entry 0 has no writable bits
	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_rw
			wire hit = cp_wr_en && cp_addr[6:3] == ADR_RW_HI &&
				cp_addr[2:0] == 3'(g);
			always_ff @(posedge clk_sys) begin
				if (srst)
					regs_q[g] <= REG_RESET[g];
				else if (hit)
					regs_q[g] <= cp_wdata & REG_WMASK[g];
			end
		end
	endgenerate

	// Field decode
	wire [7:0] r_co = regs_q[ADR_CLK_OUT[2:0]];
	wire [7:0] r_f2 = regs_q[ADR_FILT_RT0[2:0]];
	wire [7:0] r_r3 = regs_q[ADR_RT12[2:0]];
	wire [7:0] r_pw = regs_q[ADR_PWR_IN[2:0]];
	wire [7:0] r_sf = regs_q[ADR_SER_FMT[2:0]];
	wire [6:0] err_mask = regs_q[ADR_ERR_MASK[2:0]][6:0];
	wire [6:0] int_mask = regs_q[ADR_INT_MASK[2:0]][6:0];
	wire status_channel_sel = r_co[CO_CHS];
	wire run = r_pw[PW_RUN];
	wire [2:0] deemph_select = r_f2[F2_DEEMPH +: 3];
	wire arc_wsize_t wsize = arc_wsize_t'(r_sf[SF_RES +: 2]);
	wire raw_mode = wsize == ARC_RAW;

	// Routing and port format fields leave straight from the registers
	assign output0_route_sel = r_f2[F2_RT0 +: 4];
	assign output1_route_sel = r_r3[R3_RT1 +: 4];
	assign output2_route_sel = r_r3[R3_RT2 +: 4];
	assign rx_input_sel = r_pw[PW_RX +: 3];
	assign pass_input_sel = r_pw[PW_TX +: 3];
	assign port_master_sel = r_sf[SF_MS];
	assign bitclk_rate_sel = r_sf[SF_SF];
	assign output_word_size = wsize;
	assign bitclk_polarity = r_sf[SF_SPOL];
	assign frame_clk_polarity = r_sf[SF_LRPOL];

	// Unlock from the pin: three stages, accept when stages 2 and 3 agree
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			lock_s1_q <= 1'b0;
			lock_s2_q <= 1'b0;
			lock_s3_q <= 1'b0;
			lock_lost_q <= 1'b0;
		end else begin
			lock_s1_q <= lock_loss_pin;
			lock_s2_q <= lock_s1_q;
			lock_s3_q <= lock_s2_q;
			if (lock_s2_q == lock_s3_q)
				lock_lost_q <= lock_s3_q;
		end
	end

	// Error path; CRC sources are kept out of the sample decision
	// A mask write reaches the sticky bits one cycle later
	wire [6:0] err_live = err_src & err_mask;
	wire audio_err_any = |(err_live & AUDIO_ERR_MASK);
	wire receive_error_flag_live = |err_live;
	wire err_rd = cp_rd_en && cp_addr == ADR_ERR_STAT;
	wire int_rd = cp_rd_en && cp_addr == ADR_INT_STAT;
	// Set wins over the read clear, so an event in the read cycle stays
	wire [6:0] err_stat_d = ((err_rd ? 7'h00 : err_stat_q) | err_live) &
		err_mask;
	wire receive_error_flag_rise = receive_error_flag_live && !receive_error_flag_live_q;
	wire [6:0] evt_all = int_evt | (7'(receive_error_flag_rise) << INT_RECEIVE_ERROR_FLAG);
	wire [6:0] int_stat_d = ((int_rd ? 7'h00 : int_stat_q) | evt_all) &
		int_mask;

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			err_stat_q <= 7'h00;
			int_stat_q <= 7'h00;
			receive_error_flag_live_q <= 1'b0;
			receive_error_flag_q <= 1'b0;
		end else begin
			err_stat_q <= err_stat_d;
			int_stat_q <= int_stat_d;
			receive_error_flag_live_q <= receive_error_flag_live;
			receive_error_flag_q <= receive_error_flag_live;
		end
	end

	// Status channel view: selected channel's aux width and flags
	wire [3:0] sel_aux = status_channel_sel ? chb_aux : cha_aux;
	wire [3:0] sel_flags = status_channel_sel ? chb_cs_flags : cha_cs_flags;
	wire [7:0] chstat_word = {sel_aux, sel_flags};

	// Read decode; unmapped addresses read as zero
	// Reading the error or event register also clears it
	wire rw_sel = cp_addr[6:3] == ADR_RW_HI;
	wire [7:0] rd_word = rw_sel ? regs_q[cp_addr[2:0]] :
		(cp_addr == ADR_CHSTAT) ? chstat_word :
		(cp_addr == ADR_ERR_STAT) ? {1'b0, err_stat_q} :
		(cp_addr == ADR_INT_STAT) ? {1'b0, int_stat_q} : 8'h00;

	// Read data is held until the next read strobe
	always_ff @(posedge clk_sys) begin
		if (srst)
			cp_rdata_q <= 8'h00;
		else if (cp_rd_en)
			cp_rdata_q <= rd_word;
	end

	// De-emphasis choice; auto mode looks only at channel A
	wire arc_coef_t auto_coef = (non_audio || !cha_preemph) ? ARC_COEF_OFF :
		(cha_rate == CS_FS_32) ? ARC_COEF_32 :
		(cha_rate == CS_FS_44) ? ARC_COEF_44 :
		(cha_rate == CS_FS_48) ? ARC_COEF_48 : ARC_COEF_OFF;
	// Reserved select codes fall back to filter off
	wire arc_coef_t coef_d = (deemph_select == DE_32) ? ARC_COEF_32 :
		(deemph_select == DE_44) ? ARC_COEF_44 :
		(deemph_select == DE_48) ? ARC_COEF_48 :
		(deemph_select == DE_AUTO) ? auto_coef : ARC_COEF_OFF;

	// Port format: right justify only in master mode outside raw mode
	wire rjust_d = r_sf[SF_JUST] && port_master_sel && !raw_mode;
	wire delay_d = r_sf[SF_DEL] && !rjust_d;

	// Core controls, registered so every output starts from a flop
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			core_reset_q <= 1'b1;
			copy_update_en_q <= 1'b1;
			deemph_coef_q <= ARC_COEF_OFF;
			right_justify_q <= 1'b0;
			msb_delay_q <= 1'b0;
		end else begin
			core_reset_q <= !run;
			copy_update_en_q <= !r_f2[F2_COPYINH];
			deemph_coef_q <= coef_d;
			right_justify_q <= rjust_d;
			msb_delay_q <= delay_d;
		end
	end

	// Settings for the sample path
	assign cfg.policy = arc_policy_t'(r_co[CO_HOLD +: 2]);
	assign cfg.mute = r_co[CO_MUTE];
	assign cfg.word_truncate_en_en = 1'b1;
	assign cfg.aux_width = sel_aux;
	assign cfg.word_size = wsize;
	assign cfg.audio_err = audio_err_any;

	arc_sample_path u_path (
		.clk_sys(clk_sys),
		.srst(srst),
		.core_rst(core_reset_q),
		.cfg(cfg.filt),
		.sample_valid(sample_valid),
		.sample_in(sample_in),
		.out_sample_q(sample_out_q),
		.out_valid_q(sample_out_valid_q)
	);

	// Interrupt output follows any pending status bit
	wire int_any = |int_stat_q;
	wire arc_intsty_t int_style = arc_intsty_t'(r_co[CO_INT +: 2]);
	arc_pin_ctl u_pins (
		.clk_sys(clk_sys),
		.srst(srst),
		.int_active(int_any),
		.int_style(int_style),
		.lock_lost(lock_lost_q),
		.fallback_local(r_co[CO_SWCLK]),
		.rate_128(r_co[CO_RECOVERED_CLK_RATE_SEL]),
		.recovered_master_clock_off(r_pw[PW_RXD]),
		.int_pin_o_q(int_pin_o_q),
		.int_pin_oe_n_q(int_pin_oe_n_q),
		.recovered_master_clock_src_q(recovered_master_clock_src_q),
		.recovered_master_clock_div128_q(recovered_master_clock_div128_q),
		.recovered_master_clock_oe_n_q(recovered_master_clock_oe_n_q)
	);

	// Checks share clk_sys and stay quiet while srst is high
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst);

	a_run_stops_core: assert property (
		(cp_wr_en && cp_addr == ADR_PWR_IN && !cp_wdata[PW_RUN]) |=>
		##1 core_reset_q)
		else $error("core not held after run cleared");

	a_err_held: assert property (
		(!err_rd && $stable(err_mask)) |=>
		(err_stat_q & $past(err_stat_q)) == $past(err_stat_q))
		else $error("error bit lost without a read");

	a_err_masked_off: assert property (
		(err_stat_q & ~$past(err_mask)) == 7'h00)
		else $error("masked error bit visible");

	a_int_masked_off: assert property (
		(int_stat_q & ~$past(int_mask)) == 7'h00)
		else $error("masked interrupt bit visible");

	a_crc_no_alter: assert property (
		(sample_valid && (err_src & AUDIO_ERR_MASK) == 7'h00 &&
		!cfg.mute && wsize == ARC_W24 && sel_aux == 4'h0 && !core_reset_q) |=>
		sample_out_q == $past(sample_in))
		else $error("sample changed without audio error");

	a_status_chan: assert property (
		(cp_rd_en && cp_addr == ADR_CHSTAT && status_channel_sel) |=>
		cp_rdata_q[7:4] == $past(chb_aux))
		else $error("status register shows wrong channel");

	a_raw_left_just: assert property (
		raw_mode |=> !right_justify_q)
		else $error("raw mode not left justified");

	a_auto_nonaudio: assert property (
		(deemph_select == DE_AUTO && non_audio) |=>
		deemph_coef_q == ARC_COEF_OFF)
		else $error("filter on for non-audio stream");

	a_copy_inhibit: assert property (
		r_f2[F2_COPYINH] |=> !copy_update_en_q)
		else $error("copy update not inhibited");

	a_rjust_slave: assert property (
		!port_master_sel |=> !right_justify_q)
		else $error("right justify in slave mode");

	a_delay_left_only: assert property (
		right_justify_q |-> !msb_delay_q)
		else $error("delay bit active when right justified");

	a_flag_masked: assert property (
		(err_src & err_mask) == 7'h00 |=> !receive_error_flag_q)
		else $error("error flag from masked source");

	a_lock_filter: assert property (
		lock_s2_q != lock_s3_q |=> $stable(lock_lost_q))
		else $error("unlock accepted before stages agree");

	a_rdata_held: assert property (
		!cp_rd_en |=> $stable(cp_rdata_q))
		else $error("read data changed without a read");

	c_run_set: cover property (
		core_reset_q ##1 !core_reset_q);

	c_err_read_clear: cover property (
		(err_stat_q != 7'h00 && err_rd) ##1 err_stat_q == 7'h00);

	c_int_raised: cover property (
		int_stat_q == 7'h00 ##1 int_stat_q != 7'h00);

	c_clk_fallback: cover property (
		!lock_lost_q ##1 lock_lost_q && r_co[CO_SWCLK]);

	c_zero_policy: cover property (
		sample_valid && cfg.audio_err && cfg.policy == ARC_POL_ZERO);
endmodule
`default_nettype wire

/* hdl/arc_pin_ctl.sv */
// Interrupt pin drive and recovered clock source selection.
// Assumes lock_lost is already synchronised to clk_sys.
`default_nettype none
module arc_pin_ctl
	import arc_pkg::*;
(
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic int_active,
	input wire arc_intsty_t int_style,
	input wire logic lock_lost,
	input wire logic fallback_local,
	input wire logic rate_128,
	input wire logic recovered_master_clock_off,
	output var logic int_pin_o_q,
	output var logic int_pin_oe_n_q,
	output var arc_cksrc_t recovered_master_clock_src_q,
	output var logic recovered_master_clock_div128_q,
	output var logic recovered_master_clock_oe_n_q
);
	// Open drain only pulls low while active; reserved acts as high
	wire od = int_style == ARC_INT_OD;
	wire pin_o = (int_style == ARC_INT_LOW || od) ? 1'b0 : int_active;
	wire low_o = (int_style == ARC_INT_LOW) ? !int_active : pin_o;
	wire pin_oe_n = od ? !int_active : 1'b0;
	wire arc_cksrc_t ck_d = !lock_lost ? ARC_CK_PLL :
		(fallback_local ? ARC_CK_LOCAL : ARC_CK_OSC);

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			int_pin_o_q <= 1'b0;
			int_pin_oe_n_q <= 1'b0;
			recovered_master_clock_src_q <= ARC_CK_PLL;
			recovered_master_clock_div128_q <= 1'b0;
			recovered_master_clock_oe_n_q <= 1'b0;
		end else begin
			int_pin_o_q <= low_o;
			int_pin_oe_n_q <= pin_oe_n;
			recovered_master_clock_src_q <= ck_d;
			recovered_master_clock_div128_q <= rate_128;
			recovered_master_clock_oe_n_q <= recovered_master_clock_off;
		end
	end

	a_int_low_drive: assert property (@(posedge clk_sys)
		disable iff (srst)
		(int_style == ARC_INT_LOW && int_active) |=>
		(!int_pin_o_q && !int_pin_oe_n_q))
		else $error("active-low interrupt pin not low");
	a_od_release: assert property (@(posedge clk_sys)
		disable iff (srst)
		(od && !int_active) |=> int_pin_oe_n_q)
		else $error("open drain pin not released");
	a_clk_fallback: assert property (@(posedge clk_sys)
		disable iff (srst)
		(lock_lost && fallback_local) |=> recovered_master_clock_src_q == ARC_CK_LOCAL)
		else $error("local clock not forwarded on unlock");
endmodule
`default_nettype wire

/* hdl/arc_pkg.sv */
// Constants for the audio receiver control register bank.
// Assumes a single system clock domain; all users import arc_pkg::*.
`default_nettype none
package arc_pkg;
	// Register addresses on the control port
	localparam logic [6:0] ADR_CLK_OUT = 7'h01;
	localparam logic [6:0] ADR_FILT_RT0 = 7'h02;
	localparam logic [6:0] ADR_RT12 = 7'h03;
	localparam logic [6:0] ADR_PWR_IN = 7'h04;
	localparam logic [6:0] ADR_SER_FMT = 7'h05;
	localparam logic [6:0] ADR_ERR_MASK = 7'h06;
	localparam logic [6:0] ADR_INT_MASK = 7'h07;
	localparam logic [6:0] ADR_CHSTAT = 7'h0a;
	localparam logic [6:0] ADR_ERR_STAT = 7'h0c;
	localparam logic [6:0] ADR_INT_STAT = 7'h0d;
	localparam logic [3:0] ADR_RW_HI = 4'h0;
	// Reset values and writable bits, indexed by address 0..7
	localparam logic [7:0] REG_RESET [8] = '{8'h00, 8'h00, 8'h00, 8'h00,
		8'h01, 8'h00, 8'h00, 8'h00};
	localparam logic [7:0] REG_WMASK [8] = '{8'h00, 8'hff, 8'hff, 8'hff,
		8'hff, 8'hff, 8'h7f, 8'h7f};
	// Field positions (least significant bit of each field)
	localparam int CO_SWCLK = 7, CO_MUTE = 6, CO_INT = 4, CO_HOLD = 2;
	localparam int CO_RECOVERED_CLK_RATE_SEL = 1, CO_CHS = 0;
	localparam int F2_COPYINH = 7, F2_DEEMPH = 4, F2_RT0 = 0;
	localparam int R3_RT1 = 4, R3_RT2 = 0;
	localparam int PW_RUN = 7, PW_RXD = 6, PW_RX = 3, PW_TX = 0;
	localparam int SF_MS = 7, SF_SF = 6, SF_RES = 4, SF_JUST = 3;
	localparam int SF_DEL = 2, SF_SPOL = 1, SF_LRPOL = 0;
	// Error and event bit layout
	localparam logic [6:0] AUDIO_ERR_MASK = 7'h1f;
	localparam int INT_RECEIVE_ERROR_FLAG = 2;
	// De-emphasis select codes and channel-status rate codes
	localparam logic [2:0] DE_OFF = 3'h0, DE_32 = 3'h1, DE_44 = 3'h2;
	localparam logic [2:0] DE_48 = 3'h3, DE_AUTO = 3'h4;
	localparam logic [1:0] CS_FS_44 = 2'h0, CS_FS_48 = 2'h2;
	localparam logic [1:0] CS_FS_32 = 2'h3;
	// Word handling
	localparam logic [3:0] AUX_MAX = 4'h8;
	localparam logic [23:0] KEEP_ALL = 24'hffffff;
	localparam logic [23:0] KEEP_20 = 24'hfffff0;
	localparam logic [23:0] KEEP_16 = 24'hffff00;
	typedef enum logic [1:0] {ARC_POL_HOLD, ARC_POL_ZERO, ARC_POL_PASS,
		ARC_POL_RSV} arc_policy_t;
	typedef enum logic [1:0] {ARC_W24, ARC_W20, ARC_W16, ARC_RAW} arc_wsize_t;
	typedef enum logic [1:0] {ARC_INT_HIGH, ARC_INT_LOW, ARC_INT_OD,
		ARC_INT_RSV} arc_intsty_t;
	typedef enum logic [1:0] {ARC_COEF_OFF, ARC_COEF_32, ARC_COEF_44,
		ARC_COEF_48} arc_coef_t;
	typedef enum logic [1:0] {ARC_CK_PLL, ARC_CK_OSC, ARC_CK_LOCAL,
		ARC_CK_SPARE} arc_cksrc_t;
endpackage
`default_nettype wire

/* hdl/arc_sample_path.sv */
// Sample path: error policy, truncation, word size and mute.
// Assumes one sample per sample_valid pulse on clk_sys.
`default_nettype none
module arc_sample_path
	import arc_pkg::*;
(
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic core_rst,
	arc_cfg_if.filt cfg,
	input wire logic sample_valid,
	input wire logic [23:0] sample_in,
	output var logic [23:0] out_sample_q,
	output var logic out_valid_q
);
	logic [23:0] last_good_q;
	// Reserved aux widths act as no truncation
	wire aux_ok = cfg.aux_width <= AUX_MAX;
	wire is_raw = cfg.word_size == ARC_RAW;
	wire [23:0] word_truncate_en_keep = (cfg.word_truncate_en_en && aux_ok && !is_raw) ?
		(KEEP_ALL << cfg.aux_width) : KEEP_ALL;
	wire [23:0] size_keep = (cfg.word_size == ARC_W20) ? KEEP_20 :
		(cfg.word_size == ARC_W16) ? KEEP_16 : KEEP_ALL;
	// Hold is also used for the reserved policy code
	wire hold_pick = cfg.audio_err && (cfg.policy == ARC_POL_HOLD ||
		cfg.policy == ARC_POL_RSV);
	wire zero_pick = cfg.audio_err && cfg.policy == ARC_POL_ZERO;
	wire [23:0] picked = zero_pick ? 24'h000000 :
		hold_pick ? last_good_q : sample_in;
	wire [23:0] shaped = cfg.mute ? 24'h000000 :
		(picked & word_truncate_en_keep & size_keep);

	// Core reset clears the path while the block is stopped
	always_ff @(posedge clk_sys) begin
		if (srst || core_rst) begin
			out_sample_q <= 24'h000000;
			out_valid_q <= 1'b0;
			last_good_q <= 24'h000000;
		end else begin
			out_valid_q <= sample_valid;
			if (sample_valid)
				out_sample_q <= shaped;
			if (sample_valid && !cfg.audio_err)
				last_good_q <= sample_in;
		end
	end

	a_mute_zeros: assert property (@(posedge clk_sys)
		disable iff (srst)
		(sample_valid && cfg.mute && !core_rst) |=> out_sample_q == 24'h000000)
		else $error("muted sample not zero");
	a_err_zero_fill: assert property (@(posedge clk_sys)
		disable iff (srst)
		(sample_valid && zero_pick && !core_rst) |=> out_sample_q == 24'h000000)
		else $error("zero policy not applied");
endmodule
`default_nettype wire

/* verif/arc_ctrl_regs_tb_top.sv */
// Self-checking bench for the control register bank and sample path.
// Assumes the package, interface and design files are compiled first.
`default_nettype none
module arc_ctrl_regs_tb_top import arc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] FW [7] = '{8'h88, 8'h08, 8'hb8, 8'h04, 8'h8c,
		8'hc3, 8'h27};
	localparam logic [7:0] FE [7] = '{8'h88, 8'h00, 8'hb0, 8'h04, 8'h88,
		8'hc3, 8'h27};
	localparam logic [1:0] DEX [6] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3, 2'h0};
	logic clk_sys, srst, wr, rd, lock_pin, non_audio, preemph, sv;
	logic [6:0] addr, err, evt;
	logic [7:0] wdata, rdata;
	logic [3:0] aux_a, aux_b, fa, fb, r0, r1, r2;
	logic [1:0] rate;
	logic [23:0] sin, sout, sink_last;
	logic sout_v, core_rst, copy_en, right_j, msb_dly, receive_error_flag_flag;
	logic int_o, int_oe_n, div128, recovered_master_clock_oe_n, master, bclk_rate, bpol, fpol;
	logic [2:0] rx_sel, pass_sel;
	logic [15:0] sink_cnt;
	arc_coef_t coef;
	arc_wsize_t wsize;
	arc_cksrc_t ck_src;
	int fail_count, n_compared, n_sent;

	arc_ctrl_regs u_arc_ctrl_regs (.clk_sys(clk_sys), .srst(srst),
		.cp_wr_en(wr), .cp_rd_en(rd), .cp_addr(addr), .cp_wdata(wdata),
		.cp_rdata_q(rdata), .lock_loss_pin(lock_pin), .err_src(err),
		.int_evt(evt), .cha_aux(aux_a), .chb_aux(aux_b),
		.cha_cs_flags(fa), .chb_cs_flags(fb), .cha_preemph(preemph),
		.cha_rate(rate), .non_audio(non_audio), .sample_valid(sv),
		.sample_in(sin), .sample_out_q(sout), .sample_out_valid_q(sout_v),
		.core_reset_q(core_rst), .copy_update_en_q(copy_en),
		.deemph_coef_q(coef), .output0_route_sel(r0),
		.output1_route_sel(r1), .output2_route_sel(r2),
		.rx_input_sel(rx_sel), .pass_input_sel(pass_sel),
		.port_master_sel(master), .bitclk_rate_sel(bclk_rate),
		.output_word_size(wsize), .right_justify_q(right_j),
		.msb_delay_q(msb_dly), .bitclk_polarity(bpol),
		.frame_clk_polarity(fpol), .receive_error_flag_q(receive_error_flag_flag),
		.int_pin_o_q(int_o), .int_pin_oe_n_q(int_oe_n),
		.recovered_master_clock_src_q(ck_src), .recovered_master_clock_div128_q(div128),
		.recovered_master_clock_oe_n_q(recovered_master_clock_oe_n));
	arc_sink_model u_arc_sink_model (.clk_sys(clk_sys), .srst(srst),
		.smp_valid(sout_v), .smp_data(sout), .last_q(sink_last),
		.cnt_q(sink_cnt));

	// 40 MHz system clock
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	// Shared compare, counters and closing report
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic stop_test;
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	// Control port strobes last one cycle, driven on the falling edge
	task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		wr = 1'b1;
		addr = a;
		wdata = d;
		@(negedge clk_sys);
		wr = 1'b0;
	endtask
	task automatic rd_reg(input logic [6:0] a, input logic [7:0] exp);
		@(negedge clk_sys);
		rd = 1'b1;
		addr = a;
		@(negedge clk_sys);
		rd = 1'b0;
		cyc(1);
		chk(rdata, exp);
	endtask
	task automatic smp(input logic [23:0] v, input logic [23:0] exp,
		input logic vexp);
		@(negedge clk_sys);
		sv = 1'b1;
		sin = v;
		@(negedge clk_sys);
		sv = 1'b0;
		chk(sout_v, vexp);
		chk(sout, exp);
		n_sent += vexp;
	endtask
	// Bounded wait on the clock source; a hang ends the run
	task automatic wait_src(input arc_cksrc_t e);
		for (int i = 0; i < 12 && ck_src !== e; i++) cyc(1);
		chk(ck_src, e);
		if (ck_src !== e) stop_test();
	endtask

	task automatic t_reset;
		for (int a = 1; a < 8; a++) begin
			rd_reg(a[6:0], REG_RESET[a]);
		end
		chk({core_rst, copy_en, rx_sel, pass_sel}, 8'hc1);
		chk({r0, r1, r2}, 12'h000);
		smp(24'h123456, 24'h000000, 1'b0);
		$display("test reset done");
	endtask
	task automatic t_regs;
		wr_reg(7'h03, 8'ha5);
		wr_reg(7'h02, 8'h83);
		wr_reg(7'h06, 8'hff);
		wr_reg(7'h07, 8'hff);
		wr_reg(7'h00, 8'hff);
		rd_reg(7'h03, 8'ha5);
		rd_reg(7'h06, 8'h7f);
		rd_reg(7'h07, 8'h7f);
		rd_reg(7'h00, 8'h00);
		rd_reg(7'h08, 8'h00);
		chk({r0, r1, r2, copy_en}, 13'h074a);
		wr_reg(7'h04, 8'h55);
		cyc(2);
		chk({rx_sel, pass_sel, recovered_master_clock_oe_n, core_rst}, 8'h57);
		wr_reg(7'h04, 8'h81);
		wr_reg(7'h02, 8'h00);
		wr_reg(7'h06, 8'h00);
		wr_reg(7'h07, 8'h00);
		cyc(2);
		chk({recovered_master_clock_oe_n, core_rst, copy_en}, 3'b001);
		$display("test regs done");
	endtask
	task automatic t_policy;
		wr_reg(7'h06, 8'h21);
		wr_reg(7'h01, 8'h04);
		smp(24'h123456, 24'h123456, 1'b1);
		err = 7'h01;
		smp(24'h654321, 24'h000000, 1'b1);
		wr_reg(7'h01, 8'h08);
		smp(24'h654321, 24'h654321, 1'b1);
		err = 7'h00;
		smp(24'h0abcde, 24'h0abcde, 1'b1);
		wr_reg(7'h01, 8'h00);
		err = 7'h01;
		smp(24'h111111, 24'h0abcde, 1'b1);
		wr_reg(7'h01, 8'h0c);
		smp(24'h222222, 24'h0abcde, 1'b1);
		wr_reg(7'h01, 8'h04);
		err = 7'h20;
		smp(24'h333333, 24'h333333, 1'b1);
		wr_reg(7'h06, 8'h20);
		err = 7'h01;
		smp(24'h444444, 24'h444444, 1'b1);
		err = 7'h00;
		wr_reg(7'h01, 8'h40);
		smp(24'h555555, 24'h000000, 1'b1);
		wr_reg(7'h01, 8'h00);
		wr_reg(7'h06, 8'h00);
		$display("test policy done");
	endtask
	task automatic t_word_truncate_en;
		aux_a = 4'h4;
		aux_b = 4'h8;
		smp(24'hffffff, 24'hfffff0, 1'b1);
		rd_reg(7'h0a, 8'h45);
		wr_reg(7'h01, 8'h01);
		smp(24'hffffff, 24'hffff00, 1'b1);
		rd_reg(7'h0a, 8'h8a);
		wr_reg(7'h05, 8'h30);
		smp(24'hffffff, 24'hffffff, 1'b1);
		aux_b = 4'h0;
		wr_reg(7'h05, 8'h10);
		smp(24'hffffff, 24'hfffff0, 1'b1);
		wr_reg(7'h05, 8'h20);
		smp(24'hffffff, 24'hffff00, 1'b1);
		wr_reg(7'h05, 8'h00);
		wr_reg(7'h01, 8'h00);
		$display("test word_truncate_en done");
	endtask
	task automatic t_irq;
		wr_reg(7'h06, 8'h01);
		wr_reg(7'h07, 8'h04);
		for (int s = 0; s < 4; s++) begin
			wr_reg(7'h01, 8'(s << 4));
			cyc(2);
			chk(int_oe_n, s == 2);
			if (s != 2) chk(int_o, s == 1);
			err = 7'h01;
			cyc(1);
			err = 7'h00;
			cyc(3);
			chk({int_o, int_oe_n}, {s == 0 || s == 3, 1'b0});
			rd_reg(7'h0d, 8'h04);
		end
		rd_reg(7'h0c, 8'h01);
		rd_reg(7'h0c, 8'h00);
		err = 7'h01;
		cyc(2);
		chk(receive_error_flag_flag, 1'b1);
		rd_reg(7'h0c, 8'h01);
		rd_reg(7'h0c, 8'h01);
		err = 7'h00;
		wr_reg(7'h07, 8'h01);
		evt = 7'h01;
		cyc(1);
		evt = 7'h00;
		rd_reg(7'h0d, 8'h01);
		wr_reg(7'h07, 8'h00);
		evt = 7'h01;
		cyc(1);
		evt = 7'h00;
		rd_reg(7'h0d, 8'h00);
		$display("test irq done");
	endtask
	task automatic t_clock;
		lock_pin = 1'b1;
		wait_src(ARC_CK_OSC);
		wr_reg(7'h01, 8'h82);
		wait_src(ARC_CK_LOCAL);
		chk(div128, 1'b1);
		lock_pin = 1'b0;
		wait_src(ARC_CK_PLL);
		wr_reg(7'h01, 8'h00);
		cyc(2);
		chk(div128, 1'b0);
		$display("test clock done");
	endtask
	task automatic t_deemph;
		preemph = 1'b1;
		rate = CS_FS_48;
		for (int c = 0; c < 6; c++) begin
			wr_reg(7'h02, 8'(c << 4));
			cyc(2);
			chk(coef, DEX[c]);
		end
		wr_reg(7'h02, 8'h40);
		rate = CS_FS_32;
		cyc(3);
		chk(coef, ARC_COEF_32);
		preemph = 1'b0;
		cyc(3);
		chk(coef, ARC_COEF_OFF);
		preemph = 1'b1;
		non_audio = 1'b1;
		cyc(3);
		chk(coef, ARC_COEF_OFF);
		$display("test deemph done");
	endtask
	task automatic t_format;
		for (int i = 0; i < 7; i++) begin
			wr_reg(7'h05, FW[i]);
			cyc(2);
			chk({master, bclk_rate, wsize, right_j, msb_dly, bpol, fpol},
				FE[i]);
		end
		$display("test format done");
	endtask

	// Watchdog against a hung run
	initial begin
		repeat (50000) @(posedge clk_sys);
		fail_count++;
		stop_test();
	end
	// Main sequence
	initial begin
		{wr, rd, lock_pin, non_audio, preemph, sv} = 6'h00;
		{addr, err, evt, wdata} = 29'h0;
		{aux_a, aux_b, fa, fb, rate, sin} = 42'h0;
		fa = 4'h5;
		fb = 4'ha;
		srst = 1'b1;
		repeat (4) @(posedge clk_sys);
		@(negedge clk_sys);
		srst = 1'b0;
		t_reset();
		t_regs();
		t_policy();
		t_word_truncate_en();
		t_irq();
		t_clock();
		t_deemph();
		t_format();
		chk(sink_cnt, 16'(n_sent));
		chk(sink_last, 24'hffff00);
		stop_test();
	end
endmodule
`default_nettype wire

/* verif/arc_sink_model.sv */
// Downstream sink: takes each processed sample on its valid pulse.
// Assumes the block registers its sample outputs on clk_sys.
`default_nettype none
module arc_sink_model
	import arc_pkg::*;
(
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic smp_valid,
	input wire logic [23:0] smp_data,
	output var logic [23:0] last_q,
	output var logic [15:0] cnt_q
);
	timeunit 1ns;
	timeprecision 1ps;
	// Latch only on the pulse; the bus between pulses is not trusted
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			last_q <= 24'h000000;
			cnt_q <= 16'h0000;
		end else if (smp_valid) begin
			last_q <= smp_data;
			cnt_q <= cnt_q + 16'h0001;
		end
	end
endmodule
`default_nettype wire
